// ===== src/sli_params.svh
// constants for the status lamp driver: state codes and pattern timings
// assumes a 125 MHz system clock; included by the package and modules
`ifndef SLI_PARAMS_SVH
`define SLI_PARAMS_SVH
// ----------------------------------------------------------------
// state machine codes reported on the state input
// ----------------------------------------------------------------
`define SLI_ST_INIT      4'h1
`define SLI_ST_PREOP     4'h2
`define SLI_ST_BOOT      4'h3
`define SLI_ST_SAFEOP    4'h4
`define SLI_ST_OP        4'h8
// ----------------------------------------------------------------
// pattern timings in ms and the clock rate in kHz
// ----------------------------------------------------------------
`define SLI_CLK_KHZ      125000
`define SLI_BLINK_MS     200
`define SLI_FLASH_ON_MS  200
`define SLI_FLASH_OFF_MS 1000
`define SLI_FLICK_MS     50
`define SLI_ACT_MS       50
`define SLI_STRETCH_MS   100
`endif

// ===== src/sli_pkg.sv
// types shared by the status lamp driver files
// assumes sli_params.svh is on the include path
`include "sli_params.svh"
package sli_pkg;
    // lamp outputs travel together
    typedef struct packed {
        logic run;
        logic port_in;
        logic port_out;
        logic term_bus;
    } sli_lamps_s;
    // one port's link and traffic indications
    typedef struct packed {
        logic link;
        logic traffic;
    } sli_port_s;
endpackage : sli_pkg

// ===== src/sli_act_lamp.sv
// one link/activity lamp: off, steady, or blinking with stretched traffic
// assumes link and traffic inputs synchronous to clk; blink phase shared
`timescale 1ns/100ps
`default_nettype none
`include "sli_params.svh"
module sli_act_lamp
    import sli_pkg::*;
#(
    parameter int STRETCH = `SLI_STRETCH_MS * `SLI_CLK_KHZ
) (
    // clock and control
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      ce,
    // port indications and shared phase
    input  wire sli_port_s port,
    input  wire logic      act_phase,
    // lamp drive
    output logic           lamp
);
    // ----------------------------------------------------------------
    // traffic stretcher
    // ----------------------------------------------------------------
    localparam int SW = $clog2(STRETCH + 1);
    if (STRETCH < 1) begin : g_bad_stretch
        $error("stretch must be at least one cycle");
    end
    logic [SW-1:0] hold_r;   // cycles of activity still shown
    logic [SW-1:0] hold_nxt; // next hold count
    logic          active;   // traffic seen recently
    // reload on every pulse so short frames stay visible
    assign hold_nxt = port.traffic ? SW'(STRETCH) :
                      (hold_r != '0) ? hold_r - SW'(1) : hold_r;
    assign active   = port.link && (hold_r != '0);
    // stretcher register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (rst) hold_r <= '0;
        else if (ce) hold_r <= hold_nxt;
    end
    // lamp register: dark / steady / blinking
    always_ff @(posedge clk) begin
        if (rst) lamp <= 1'b0;
        else if (ce) lamp <= port.link && (!active || act_phase);
    end
    chk_dark_nolink: assert property (@(posedge clk) disable iff (rst)
        (ce && !port.link) |=> !lamp) else $error("lamp lit without link");
    chk_idle_steady: assert property (@(posedge clk) disable iff (rst)
        (ce && port.link && hold_r == '0 && !port.traffic) |=> lamp)
        else $error("idle link lamp not steady");
endmodule : sli_act_lamp
`default_nettype wire

// ===== src/sli_status_lamps.sv
// lamp driver: run lamp from state machine, three link/activity lamps
// assumes all inputs synchronous to clk; lamps driven high = lit
`timescale 1ns/100ps
`default_nettype none
`include "sli_params.svh"
module sli_status_lamps
    import sli_pkg::*;
#(
    parameter int BLINK_CYC   = `SLI_BLINK_MS * `SLI_CLK_KHZ,
    parameter int FLASH_ON    = `SLI_FLASH_ON_MS * `SLI_CLK_KHZ,
    parameter int FLASH_OFF   = `SLI_FLASH_OFF_MS * `SLI_CLK_KHZ,
    parameter int FLICK_CYC   = `SLI_FLICK_MS * `SLI_CLK_KHZ,
    parameter int ACT_CYC     = `SLI_ACT_MS * `SLI_CLK_KHZ,
    parameter int STRETCH_CYC = `SLI_STRETCH_MS * `SLI_CLK_KHZ
) (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // communication state code
    input  wire logic [3:0] sm_state,
    // port indications
    input  wire sli_port_s  incoming_port,
    input  wire sli_port_s  outgoing_port,
    input  wire sli_port_s  term_bus,
    // lamp drives
    output sli_lamps_s      lamps
);
    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    // refused at elaboration, before any counter is built at all
    if (BLINK_CYC < 1 || FLICK_CYC < 1 || ACT_CYC < 1) begin : g_bad_half
        $error("pattern half periods must be at least one cycle");
    end
    if (FLASH_ON < 1 || FLASH_OFF <= FLASH_ON) begin : g_bad_flash
        $error("flash dark interval must exceed flash pulse");
    end
    if (STRETCH_CYC < 1) begin : g_bad_stretch
        $error("activity stretch must be at least one cycle");
    end
    // one width for every counter: the flash frame is the longest count,
    // and a shared width keeps the wrap function common to all of them
    localparam int PW = 32;
    // run lamp pattern selector
    typedef enum logic [2:0] {
        SLI_RUN_OFF   = 3'b000,
        SLI_RUN_BLINK = 3'b001,
        SLI_RUN_FLASH = 3'b010,
        SLI_RUN_ON    = 3'b011,
        SLI_RUN_FLICK = 3'b100
    } sli_run_e;
    // ----------------------------------------------------------------
    // free-running pattern counters
    // ----------------------------------------------------------------
    // wrap test used by every toggle counter
    function automatic logic at_end(input logic [PW-1:0] c, input int lim);
        at_end = (c >= PW'(lim - 1));
    endfunction : at_end
    logic [PW-1:0] blink_cnt_r;  // blink half period
    logic [PW-1:0] flick_cnt_r;  // flicker half period
    logic [PW-1:0] act_cnt_r;    // activity half period
    logic [PW-1:0] flash_cnt_r;  // flash frame position
    logic          blink_ph_r;   // blink phase
    logic          flick_ph_r;   // flicker phase
    logic          act_ph_r;     // activity phase
    wire           blink_end = at_end(blink_cnt_r, BLINK_CYC);
    wire           flick_end = at_end(flick_cnt_r, FLICK_CYC);
    wire           act_end   = at_end(act_cnt_r, ACT_CYC);
    wire           flash_end = at_end(flash_cnt_r, FLASH_ON + FLASH_OFF);
    // short pulse at frame start, long dark rest
    wire           flash_ph  = (flash_cnt_r < PW'(FLASH_ON));
    // counters run regardless of state so lamps agree in phase
    always_ff @(posedge clk) begin
        if (rst) begin
            blink_cnt_r <= '0;
            flick_cnt_r <= '0;
            act_cnt_r   <= '0;
            flash_cnt_r <= '0;
            blink_ph_r  <= 1'b0;
            flick_ph_r  <= 1'b0;
            act_ph_r    <= 1'b0;
        end else if (ce) begin
            blink_cnt_r <= blink_end ? '0 : blink_cnt_r + PW'(1);
            flick_cnt_r <= flick_end ? '0 : flick_cnt_r + PW'(1);
            act_cnt_r   <= act_end ? '0 : act_cnt_r + PW'(1);
            flash_cnt_r <= flash_end ? '0 : flash_cnt_r + PW'(1);
            blink_ph_r  <= blink_ph_r ^ blink_end;
            flick_ph_r  <= flick_ph_r ^ flick_end;
            act_ph_r    <= act_ph_r ^ act_end;
        end
    end
    // ----------------------------------------------------------------
    // run lamp
    // ----------------------------------------------------------------
    sli_run_e run_sel;  // pattern chosen from state
    logic     run_nxt;  // next run lamp level
    logic     run_r;    // registered run lamp
    logic     in_lamp;  // incoming port lamp, from its flop
    logic     out_lamp; // outgoing port lamp, from its flop
    logic     bus_lamp; // terminal bus lamp, from its flop
    // unknown codes show dark, the safe reading for an operator
    always_comb begin
        case (sm_state)
            `SLI_ST_PREOP:  run_sel = SLI_RUN_BLINK;
            `SLI_ST_SAFEOP: run_sel = SLI_RUN_FLASH;
            `SLI_ST_OP:     run_sel = SLI_RUN_ON;
            `SLI_ST_BOOT:   run_sel = SLI_RUN_FLICK;
            default:        run_sel = SLI_RUN_OFF;
        endcase
    end
    always_comb begin
        case (run_sel)
            SLI_RUN_BLINK: run_nxt = blink_ph_r;
            SLI_RUN_FLASH: run_nxt = flash_ph;
            SLI_RUN_ON:    run_nxt = 1'b1;
            SLI_RUN_FLICK: run_nxt = flick_ph_r;
            default:       run_nxt = 1'b0;
        endcase
    end
    // registered lamp drive, dark during reset
    always_ff @(posedge clk) begin
        if (rst) run_r <= 1'b0;
        else if (ce) run_r <= run_nxt;
    end
    // ----------------------------------------------------------------
    // link/activity lamps
    // ----------------------------------------------------------------
    sli_act_lamp #(.STRETCH(STRETCH_CYC)) u_in (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .port      (incoming_port),
        .act_phase (act_ph_r),
        .lamp      (in_lamp)
    );
    sli_act_lamp #(.STRETCH(STRETCH_CYC)) u_out (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .port      (outgoing_port),
        .act_phase (act_ph_r),
        .lamp      (out_lamp)
    );
    sli_act_lamp #(.STRETCH(STRETCH_CYC)) u_bus (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .port      (term_bus),
        .act_phase (act_ph_r),
        .lamp      (bus_lamp)
    );
    // ----------------------------------------------------------------
    // lamp bundle
    // ----------------------------------------------------------------
    // a single driver for the whole struct: a clocked field next to
    // instance-driven fields would give one variable two kinds of driver
    assign lamps = '{run: run_r, port_in: in_lamp, port_out: out_lamp,
                     term_bus: bus_lamp};
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // enabled cycle in a given state
    sequence s_ce_in(logic [3:0] code);
        ce && sm_state == code;
    endsequence
    // traffic seen on a linked port, then a given activity phase
    sequence s_busy_in(logic lnk, logic trf, logic ph);
        (ce && lnk && trf) ##1 (ce && lnk && act_ph_r == ph);
    endsequence
    chk_init_dark: assert property (@(posedge clk) disable iff (rst)
        s_ce_in(`SLI_ST_INIT) |=> !lamps.run) else $error("run lit in init");
    chk_op_steady: assert property (@(posedge clk) disable iff (rst)
        s_ce_in(`SLI_ST_OP) |=> lamps.run) else $error("run dark in operational");
    chk_preop_blink: assert property (@(posedge clk) disable iff (rst)
        s_ce_in(`SLI_ST_PREOP) |=> lamps.run == $past(blink_ph_r))
        else $error("run not blink in preop");
    chk_flash_pulse: assert property (@(posedge clk) disable iff (rst)
        s_ce_in(`SLI_ST_SAFEOP) |=> lamps.run == $past(flash_cnt_r < PW'(FLASH_ON)))
        else $error("run not single flash in safeop");
    chk_boot_flick: assert property (@(posedge clk) disable iff (rst)
        s_ce_in(`SLI_ST_BOOT) |=> lamps.run == $past(flick_ph_r))
        else $error("run not flicker in bootstrap");
    chk_blink_toggle: assert property (@(posedge clk) disable iff (rst)
        (ce && blink_end) |=> blink_ph_r != $past(blink_ph_r))
        else $error("blink phase did not toggle");
    chk_flick_toggle: assert property (@(posedge clk) disable iff (rst)
        (ce && flick_end) |=> flick_ph_r != $past(flick_ph_r))
        else $error("flicker phase did not toggle");
    chk_flash_wrap: assert property (@(posedge clk) disable iff (rst)
        (ce && flash_end) |=> flash_cnt_r == '0)
        else $error("flash frame did not restart");
    // dark half of the activity blink on every port lamp, lit half on the incoming lamp only, then outgoing and bus lamps dark without link
    chk_in_blink: assert property (@(posedge clk) disable iff (rst)
        s_busy_in(incoming_port.link, incoming_port.traffic, 1'b0) |=> !lamps.port_in)
        else $error("incoming lamp not blinking on traffic");
    chk_in_lit: assert property (@(posedge clk) disable iff (rst)
        s_busy_in(incoming_port.link, incoming_port.traffic, 1'b1) |=> lamps.port_in)
        else $error("incoming lamp dark in lit blink phase");
    chk_out_blink: assert property (@(posedge clk) disable iff (rst)
        s_busy_in(outgoing_port.link, outgoing_port.traffic, 1'b0) |=> !lamps.port_out)
        else $error("outgoing lamp not blinking on traffic");
    chk_bus_blink: assert property (@(posedge clk) disable iff (rst)
        s_busy_in(term_bus.link, term_bus.traffic, 1'b0) |=> !lamps.term_bus)
        else $error("bus lamp not blinking on traffic");
    chk_bus_dark: assert property (@(posedge clk) disable iff (rst)
        (ce && !term_bus.link) |=> !lamps.term_bus)
        else $error("bus lamp lit without connection");
    chk_out_dark: assert property (@(posedge clk) disable iff (rst)
        (ce && !outgoing_port.link) |=> !lamps.port_out)
        else $error("outgoing lamp lit without link");
endmodule : sli_status_lamps
`default_nettype wire

// ===== bench/sli_lamp_viewer.sv
// viewer model: counts lit samples and changes of one chosen lamp
// assumes lamps are registered on clk; clear opens a new viewing window
`timescale 1ns/100ps
`default_nettype none
module sli_lamp_viewer
    import sli_pkg::*;
(
    // clock and window control
    input  wire logic       clk,
    input  wire logic       clear,
    input  wire logic [1:0] sel,
    // lamps as the viewer sees them
    input  wire sli_lamps_s lamps,
    // what the viewer counted
    output logic [15:0]     lit_r,
    output logic [15:0]     chg_r
);
    // -------------------------------------------------------------
    // observation
    // -------------------------------------------------------------
    logic cur;     // lamp being watched
    logic prev_r;  // last look, to spot changes
    assign cur = lamps[sel];
    // a person sees on time and changes only, never the phase
    always_ff @(posedge clk) begin
        if (clear) begin
            lit_r  <= 16'h0;
            chg_r  <= 16'h0;
        end else begin
            lit_r  <= lit_r + {15'h0, cur};
            chg_r  <= chg_r + {15'h0, cur != prev_r};
        end
        prev_r <= cur;
    end
endmodule : sli_lamp_viewer
`default_nettype wire

// ===== bench/testbench.sv
// bench for the lamp driver: drives state and ports, viewer counts lamps
// assumes the short simulation timings; windows are whole pattern periods
`timescale 1ns/100ps
`default_nettype none
`include "sli_params.svh"
module testbench
    import sli_pkg::*;
#(
    // short pattern timings; the window must hold whole periods of each
    parameter int BLINK_SIM     = 8,
    parameter int FLASH_ON_SIM  = 3,
    parameter int FLASH_OFF_SIM = 12,
    parameter int FLICK_SIM     = 2,
    parameter int ACT_SIM       = 2,
    parameter int STRETCH_SIM   = 10
);
    // -------------------------------------------------------------
    // signals and tables
    // -------------------------------------------------------------
    logic        clk, rst, ce, clear;
    logic [3:0]  sm_state;
    logic [1:0]  sel;
    sli_port_s   ports [3];   // incoming, outgoing, terminal bus
    sli_lamps_s  lamps;
    logic [15:0] lit_cnt, chg_cnt;
    int          miscompares, samples_checked;
    // viewing window: whole periods of every pattern (16, 15 and 4 cycles)
    localparam int WIN   = 240;
    localparam int FRAME = FLASH_ON_SIM + FLASH_OFF_SIM;
    logic [3:0]  st_code [6] = '{`SLI_ST_INIT, `SLI_ST_PREOP, `SLI_ST_SAFEOP,
                                 `SLI_ST_OP, `SLI_ST_BOOT, 4'h5};
    // expected lit samples and changes: half lit for square waves, one
    // pulse per flash frame, two changes per period
    logic [15:0] st_lit  [6] = '{16'h0, 16'(WIN / 2), 16'(WIN / FRAME * FLASH_ON_SIM),
                                 16'(WIN), 16'(WIN / 2), 16'h0};
    logic [15:0] st_chg  [6] = '{16'h0, 16'(WIN / BLINK_SIM), 16'(2 * WIN / FRAME),
                                 16'h0, 16'(WIN / FLICK_SIM), 16'h0};
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    sli_status_lamps #(.BLINK_CYC(BLINK_SIM), .FLASH_ON(FLASH_ON_SIM),
                       .FLASH_OFF(FLASH_OFF_SIM), .FLICK_CYC(FLICK_SIM),
                       .ACT_CYC(ACT_SIM), .STRETCH_CYC(STRETCH_SIM)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .sm_state(sm_state),
        .incoming_port(ports[0]), .outgoing_port(ports[1]), .term_bus(ports[2]),
        .lamps(lamps));
    sli_lamp_viewer i_view (.clk(clk), .clear(clear), .sel(sel), .lamps(lamps),
                            .lit_r(lit_cnt), .chg_r(chg_cnt));
    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask : check
    // settle, then watch one lamp for one window; ffff skips the lit count
    task automatic look(input logic [1:0] s, input logic [15:0] lit,
                        input logic [15:0] chg);
        repeat (24) @(negedge clk);
        sel   = s;
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        repeat (WIN) @(negedge clk);
        if (lit !== 16'hffff) check(lit_cnt, lit);
        check(chg_cnt, chg);
    endtask : look
    task automatic report_and_stop;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // -------------------------------------------------------------
    // sequence
    // -------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("ERROR at %0t: run too long", $time);
        report_and_stop();
    end
    initial begin
        rst = 1'b1; ce = 1'b1; clear = 1'b1; sel = 2'h3; sm_state = `SLI_ST_OP;
        foreach (ports[i]) ports[i] = '0;
        miscompares = 0; samples_checked = 0;
        repeat (12) @(negedge clk);
        check({12'h0, lamps}, 16'h0);
        rst = 1'b0;
        // every state code, unknown one included, on the run lamp
        for (int k = 0; k < 6; k++) begin
            sm_state = st_code[k];
            look(2'h3, st_lit[k], st_chg[k]);
        end
        // frozen clock enable stops the flicker
        sm_state = `SLI_ST_BOOT;
        ce = 1'b0;
        look(2'h3, 16'hffff, 16'h0);
        ce = 1'b1;
        // each link/activity lamp: dark, steady, traffic, stop, no link
        for (int p = 0; p < 3; p++) begin
            ports[p] = '{link: 1'b0, traffic: 1'b0};
            look(2'(2 - p), 16'h0, 16'h0);
            ports[p].link = 1'b1;
            look(2'(2 - p), 16'(WIN), 16'h0);
            ports[p].traffic = 1'b1;
            look(2'(2 - p), 16'(WIN / 2), 16'(WIN / ACT_SIM));
            ports[p].traffic = 1'b0;
            look(2'(2 - p), 16'(WIN), 16'h0);
            ports[p] = '{link: 1'b0, traffic: 1'b1};
            look(2'(2 - p), 16'h0, 16'h0);
            ports[p] = '0;
        end
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
